// ---- pic_combiner.v ----
// What this block does
// RL1 - Enable bit zero keeps the combined interrupt output low.
// RL2 - Enabled with zero pacing count, any active source raises the output.
// RL3 - Pacing counter reloads only on enable going from 0 to 1.
// RL4 - Pacing counter decrements once per clock/6 tick, stops at zero.
// RL5 - Non-zero pacing counter blocks output assertion.
// RL6 - Count field is bits 16:0; bits 31:17 read zero.
// RL7 - Count field resets to zero, pacing inactive.
// RL8 - Enable resets to zero; control bits 31:1 read zero.
// RL9 - Software clears enable on entry, clears sources, re-enables on exit.
// RL10 - Sources still pending at re-enable produce a fresh rising edge.
// RL11 - Source lines are level-sensitive and held while their condition persists.
// RL12 - Output is registered on the peripheral tick for clean edges; a cleared enable drops it on the next clock.
`timescale 1ns/100ps
`default_nettype none
`include "pic_defines.vh"

module pic_combiner (
    // Clock and reset
    input  wire                         pclk,
    input  wire                         presetn,
    // APB slave
    input  wire                         psel,
    input  wire                         penable,
    input  wire                         pwrite,
    input  wire [`PIC_ADDR_W-1:0]       paddr,
    input  wire [31:0]                  pwdata,
    output reg  [31:0]                  prdata,
    output reg                          pready,
    output reg                          pslverr,
    // Level interrupt sources
    input  wire [`PIC_MAC_SRC_W-1:0]    mac_irq,
    input  wire [`PIC_MDIO_SRC_W-1:0]   mdio_irq,
    // Combined request to the CPU
    output reg                          combined_irq_out
);

    // ----------------------------------------
    // Registers and bus decode
    // ----------------------------------------
    reg                      combined_irq_enable;
    reg  [`PIC_CNT_W-1:0]    pacing_count;
    wire                     bus_setup;
    wire                     wr_ctrl;
    wire                     wr_count;
    wire                     hit_ctrl;
    wire                     hit_count;
    wire                     enable_rise;
    wire                     tick;
    wire                     pace_busy;
    wire                     any_source;
    reg  [31:0]              next_prdata;

    assign hit_ctrl  = (paddr == `PIC_OFF_CTRL);
    assign hit_count = (paddr == `PIC_OFF_COUNT);
    // Answer in the access phase, one cycle after setup
    assign bus_setup = psel && !penable;
    assign wr_ctrl   = psel && penable && pready && pwrite && hit_ctrl;
    assign wr_count  = psel && penable && pready && pwrite && hit_count;

    // Zero wait states: pready raised for the access cycle only
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= bus_setup;
            pslverr <= bus_setup && !hit_ctrl && !hit_count;
            if (bus_setup) begin
                prdata <= next_prdata; // Zero on unmapped, so an error answer reads zero
            end
        end
    end

    // Read mux; reserved bits read zero
    always @* begin
        next_prdata = 32'h0000_0000;
        if (hit_ctrl) begin
            next_prdata[`PIC_EN_BIT] = combined_irq_enable; // RL8
        end else if (hit_count) begin
            next_prdata[`PIC_CNT_W-1:0] = pacing_count; // RL6
        end
    end

    // Software registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            combined_irq_enable <= `PIC_CTRL_RESET; // RL8
            pacing_count        <= `PIC_COUNT_RESET; // RL7
        end else begin
            if (wr_ctrl) begin
                combined_irq_enable <= pwdata[`PIC_EN_BIT];
            end
            if (wr_count) begin
                pacing_count <= pwdata[`PIC_CNT_W-1:0]; // RL6
            end
        end
    end

    // ----------------------------------------
    // Pacing
    // ----------------------------------------
    // Reload only on a 0 to 1 write of the enable
    assign enable_rise = wr_ctrl && pwdata[`PIC_EN_BIT] && !combined_irq_enable; // RL3

    pic_divider #(
        .DIV   (`PIC_PERIPH_DIV),
        .CNT_W (`PIC_DIV_W)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    // Down-counter stepped by the peripheral tick
    pic_pace_counter #(
        .W (`PIC_CNT_W)
    ) u_pace (
        .pclk       (pclk),
        .presetn    (presetn),
        .load       (enable_rise),
        .load_value (pacing_count),
        .tick       (tick), // RL4
        .busy       (pace_busy)
    );

    // ----------------------------------------
    // Combined output
    // ----------------------------------------
    // Sources are levels; any one active asks for service
    assign any_source = (|mac_irq) || (|mdio_irq); // RL11

    // Updated on the peripheral tick; drops at once on disable
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            combined_irq_out <= 1'b0;
        end else if (!combined_irq_enable) begin
            combined_irq_out <= 1'b0; // RL1
        end else if (tick) begin
            // RL2 RL5 RL10 RL12
            combined_irq_out <= any_source && !pace_busy && !enable_rise;
        end
    end

endmodule

`default_nettype wire

// ---- pic_combiner_asserts.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pic_defines.vh"
module pic_chk (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`PIC_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt lines
    input wire logic [`PIC_MAC_SRC_W-1:0] mac_irq,
    input wire logic [`PIC_MDIO_SRC_W-1:0] mdio_irq,
    input wire logic combined_irq_out
);
    // Decoded events
    wire irq = combined_irq_out;
    wire src = |{mac_irq, mdio_irq};
    wire rd = pready & !pwrite;
    wire off = pready & pwrite & paddr == `PIC_OFF_CTRL & !pwdata[0];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ans; psel && !penable |=> pready; endproperty
    a_ans: assert property (p_ans) else $error("no answer after setup");
    property p_err; pslverr |-> pready && prdata == 0; endproperty
    a_err: assert property (p_err) else $error("stray error answer");
    property p_off; off |=> ##1 !irq; endproperty
    a_off: assert property (p_off) else $error("output high while disabled");
    property p_cnt; rd && paddr == `PIC_OFF_COUNT |-> prdata[31:17] == 0; endproperty
    a_cnt: assert property (p_cnt) else $error("count upper bits set");
    property p_ctl; rd && paddr == `PIC_OFF_CTRL |-> prdata[31:1] == 0; endproperty
    a_ctl: assert property (p_ctl) else $error("control upper bits set");
    property p_rise; $rose(irq) |-> $past(src); endproperty
    a_rise: assert property (p_rise) else $error("rise with no source");
    property p_space; $rose(irq) |=> !$rose(irq) [*5]; endproperty
    a_space: assert property (p_space) else $error("rise off the tick");
    property p_fall; $fell(irq) |-> !$past(src) || $past(off) || $past(off, 2); endproperty
    a_fall: assert property (p_fall) else $error("fall with source held");
endmodule
bind pic_combiner pic_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .mac_irq(mac_irq),
    .mdio_irq(mdio_irq), .combined_irq_out(combined_irq_out));
`default_nettype wire

// ---- pic_combiner_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "pic_defines.vh"
module pic_combiner_test;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, se;
    logic [`PIC_ADDR_W-1:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic [`PIC_MAC_SRC_W-1:0] mac_irq = 0;
    logic [`PIC_MDIO_SRC_W-1:0] mdio_irq = 0;
    int err_total = 0, total_checks = 0, edges, n;
    always #2.5 pclk = ~pclk;
    pic_combiner dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mac_irq(mac_irq), .mdio_irq(mdio_irq), .combined_irq_out(irq));
    pic_cpu_intc cpu (.pclk(pclk), .presetn(presetn), .irq(irq), .edges(edges));
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One bus transfer, held until pready
    task automatic apb(logic w, logic [`PIC_ADDR_W-1:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n == 20) err_total++;
        rd = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_irq(logic v, int lim);
        n = 0;
        while (irq !== v && n < lim) begin
            @(posedge pclk);
            n++;
        end
        chk("irq", irq, v);
    endtask
    // Main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `PIC_OFF_CTRL, 0);
        chk("ctrl", rd, 0);
        apb(0, `PIC_OFF_COUNT, 0);
        chk("count", rd, 0);
        apb(1, `PIC_OFF_COUNT, 32'hFFFFFFFF);
        apb(0, `PIC_OFF_COUNT, 0);
        chk("count max", rd, 32'h0001FFFF);
        apb(1, `PIC_OFF_COUNT, 0);
        apb(0, 12'h00C, 0);
        chk("unmapped", {se, rd[30:0]}, 32'h80000000);
        mac_irq <= 18'h00001;
        repeat (20) @(posedge pclk);
        chk("disabled", irq, 0);
        apb(1, `PIC_OFF_CTRL, 32'hFFFFFFFF);
        apb(0, `PIC_OFF_CTRL, 0);
        chk("ctrl rw", rd, 1);
        wait_irq(1, 20);
        apb(1, `PIC_OFF_COUNT, 32'h00000064);
        apb(1, `PIC_OFF_CTRL, 1);
        repeat (20) @(posedge pclk);
        chk("no reload", irq, 1);
        apb(1, `PIC_OFF_CTRL, 0);
        wait_irq(0, 3);
        mac_irq <= 18'h00000;
        mdio_irq <= 2'h2;
        apb(1, `PIC_OFF_COUNT, 3);
        apb(1, `PIC_OFF_CTRL, 1);
        wait_irq(1, 40);
        chk("pace gap", n > 3 * `PIC_PERIPH_DIV, 1);
        chk("pace end", n <= 4 * `PIC_PERIPH_DIV + 2, 1);
        @(posedge pclk);
        chk("edges", edges, 2);
        mdio_irq <= 2'h0;
        wait_irq(0, 20);
        complete_run;
    end
    // Watchdog
    initial begin
        #50000;
        err_total++;
        complete_run;
    end
endmodule
`default_nettype wire

// ---- pic_cpu_intc.sv ----
`timescale 1ns/100ps
`default_nettype none
// Edge-sensitive CPU input: counts request edges
module pic_cpu_intc (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic irq,
    output var int edges
);
    logic last;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last <= 1'b0;
            edges <= 0;
        end else begin
            last <= irq;
            if (irq && !last) edges <= edges + 1;
        end
    end
endmodule
`default_nettype wire

// ---- pic_defines.vh ----
`ifndef PIC_DEFINES_VH
`define PIC_DEFINES_VH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define PIC_ADDR_W          12
`define PIC_OFF_CTRL        12'h004
`define PIC_OFF_COUNT       12'h008

// ----------------------------------------
// Field layout and reset values
// ----------------------------------------
`define PIC_EN_BIT          0
`define PIC_CNT_W           17
`define PIC_CTRL_RESET      1'h0
`define PIC_COUNT_RESET     17'h00000

// ----------------------------------------
// Source lines and timing
// ----------------------------------------
`define PIC_MAC_SRC_W       18
`define PIC_MDIO_SRC_W      2
`define PIC_CLK_MHZ         200
`define PIC_PERIPH_DIV      6
`define PIC_DIV_W           3

`endif

// ---- pic_divider.v ----
`timescale 1ns/100ps
`default_nettype none

// Divide-by-N tick: one-cycle enable pulse every N clocks
module pic_divider #(
    parameter integer DIV   = 6,
    parameter integer CNT_W = 3
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Tick output
    output reg              tick
);

    reg  [CNT_W-1:0] count;

    // Free-running count with terminal pulse
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b0;
        end else if (count == DIV[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1}) begin
            count <= {CNT_W{1'b0}};
            tick  <= 1'b1;
        end else begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// ---- pic_pace_counter.v ----
`timescale 1ns/100ps
`default_nettype none

// Loadable down-counter that stops at zero
module pic_pace_counter #(
    parameter integer W = 17
) (
    // Clock and reset
    input  wire             pclk,
    input  wire             presetn,
    // Control
    input  wire             load,
    input  wire [W-1:0]     load_value,
    input  wire             tick,
    // Status
    output wire             busy
);

    reg  [W-1:0] remaining;

    // Load wins over a tick in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remaining <= {W{1'b0}};
        end else if (load) begin
            remaining <= load_value;
        end else if (tick && remaining != {W{1'b0}}) begin
            remaining <= remaining - {{(W-1){1'b0}}, 1'b1};
        end
    end

    assign busy = (remaining != {W{1'b0}});

endmodule

`default_nettype wire
